// ### core/bte_defines.svh
`ifndef BTE_DEFINES_SVH
`define BTE_DEFINES_SVH

// ==========================================================
// widths
`define BTE_NUM_ERR        5
`define BTE_CNT_W          16
`define BTE_IDX_W          6
`define BTE_IN_GAIN_W      4

// ==========================================================
// error flag positions
`define BTE_ERR_IOV        0
`define BTE_ERR_CLIP       1
`define BTE_ERR_GAIN       2
`define BTE_ERR_CLAMP      3
`define BTE_ERR_OUT        4

// ==========================================================
// register indices, byte address is four times the index
`define BTE_REG_GAIN       6'h00
`define BTE_REG_GUARD_DUR  6'h03
`define BTE_REG_ERR_STAT   6'h04
`define BTE_REG_STATUS     6'h05
`define BTE_REG_CONFIG     6'h06
`define BTE_REG_ERR_MASK   6'h07
`define BTE_REG_SUPP_DLY   6'h0b
`define BTE_REG_CMD        6'h0e

// ==========================================================
// field positions
`define BTE_CMD_TRIG_BIT   5
`define BTE_GAIN_OUT_BIT   4
`define BTE_CFG_LATCH_OFF  0
`define BTE_CFG_SUPP_EN    1
`define BTE_STAT_GUARD     0

// ==========================================================
// reset values
`define BTE_IN_GAIN_RST    4'h0
`define BTE_OUT_GAIN_RST   1'b0
`define BTE_GUARD_DUR_RST  16'h0064
`define BTE_SUPP_DLY_RST   16'h000a
`define BTE_ERR_MASK_RST   5'h00
`define BTE_LATCH_OFF_RST  1'b0
`define BTE_SUPP_EN_RST    1'b1

`endif

// ### core/bte_filt_if.sv
`include "bte_defines.svh"
interface bte_filt_if;

  // ==========================================================
  // sensor filter link
  logic [`BTE_NUM_ERR-1:0] sensors;
  logic                    suppress;
  logic [`BTE_CNT_W-1:0]   delay;
  logic [`BTE_NUM_ERR-1:0] filtered;

  modport ctl (output sensors, output suppress, output delay, input filtered);
  modport flt (input sensors, input suppress, input delay, output filtered);

endinterface

// ### core/bte_filter.sv
`include "bte_defines.svh"
module bte_filter (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // sensor link
  bte_filt_if.flt   f
);

  bte_pkg::bte_filt_state_type q_r;
  bte_pkg::bte_filt_state_type q_nxt;

  // ==========================================================
  // per-sensor persistence counters
  // a sensor must stay high for delay+1 cycles before its output rises
  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < `BTE_NUM_ERR; i++) begin
      if (f.suppress || !f.sensors[i]) begin
        q_nxt.cnt[i] = '0;
        q_nxt.out[i] = 1'b0;
      end else if (q_r.cnt[i] >= f.delay) begin
        q_nxt.out[i] = 1'b1;
      end else begin
        q_nxt.cnt[i] = q_r.cnt[i] + 16'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign f.filtered = q_r.out;

endmodule

// ### core/bte_pkg.sv
`include "bte_defines.svh"
package bte_pkg;

  // ==========================================================
  // top-level state
  typedef struct packed {
    logic [`BTE_NUM_ERR:0]    sync1;
    logic [`BTE_NUM_ERR:0]    sync2;
    logic                     pin_q;
    logic                     wr_pend;
    logic [`BTE_IDX_W-1:0]    wr_idx;
    logic [31:0]              rdata;
    logic                     hreadyout;
    logic                     hresp;
    logic [`BTE_IN_GAIN_W-1:0] in_gain;
    logic                     out_gain_hi;
    logic [`BTE_CNT_W-1:0]    guard_dur;
    logic [`BTE_CNT_W-1:0]    guard_cnt;
    logic                     guard_act;
    logic [`BTE_NUM_ERR-1:0]  err_st;
    logic [`BTE_NUM_ERR-1:0]  err_mask;
    logic                     latch_off;
    logic                     supp_en;
    logic [`BTE_CNT_W-1:0]    supp_dly;
    logic                     irq;
  } bte_state_type;

  // ==========================================================
  // filter state
  typedef struct packed {
    logic [`BTE_NUM_ERR-1:0][`BTE_CNT_W-1:0] cnt;
    logic [`BTE_NUM_ERR-1:0]                 out;
  } bte_filt_state_type;

endpackage

// ### core/bte_top.sv
// Added by the designer: the AHB-Lite register port and the register addresses.
`include "bte_defines.svh"
module bte_top (
  // clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // ahb-lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // external pins and path sensors, asynchronous
  input  wire logic                      guard_trigger_pin,
  input  wire logic                      iov_sense,
  input  wire logic                      clip_sense,
  input  wire logic                      gain_sense,
  input  wire logic                      clamp_sense,
  input  wire logic                      outfault_sense,
  // control outputs
  output logic                           guard_active_flag,
  output logic [`BTE_IN_GAIN_W-1:0]      in_gain_sel,
  output logic                           out_gain_high,
  output logic                           err_irq
);

  // ==========================================================
  // state
  bte_pkg::bte_state_type q_r;
  bte_pkg::bte_state_type q_nxt;

  bte_filt_if filt_if ();

  logic [`BTE_NUM_ERR-1:0] raw_sense;
  logic                    pin_rise;
  logic                    cmd_trig;
  logic                    guard_trig;
  logic                    addr_ok;
  logic [`BTE_IDX_W-1:0]   addr_idx;
  logic [`BTE_NUM_ERR-1:0] w1c;
  logic [`BTE_NUM_ERR-1:0] err_set;
  logic [`BTE_CNT_W-1:0]   guard_last;

  // sensor order matches the error status layout
  always_comb begin
    raw_sense                 = '0;
    raw_sense[`BTE_ERR_IOV]   = iov_sense;
    raw_sense[`BTE_ERR_CLIP]  = clip_sense;
    raw_sense[`BTE_ERR_GAIN]  = gain_sense;
    raw_sense[`BTE_ERR_CLAMP] = clamp_sense;
    raw_sense[`BTE_ERR_OUT]   = outfault_sense;
  end

  // ==========================================================
  // suppression delay filter
  assign filt_if.sensors  = q_r.sync2[`BTE_NUM_ERR-1:0];
  assign filt_if.suppress = q_r.supp_en & q_r.guard_act;
  assign filt_if.delay    = q_r.supp_dly;

  bte_filter u_filter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .f       (filt_if.flt)
  );

  assign err_set = filt_if.filtered;

  // ==========================================================
  // address decode
  // only the low 256 bytes are mapped; anything above reads zero
  assign addr_ok  = (haddr[31:8] == 24'h000000);
  assign addr_idx = haddr[7:2];

  // read mux, sampled in the address phase
  function automatic logic [31:0] rd_value(input logic [`BTE_IDX_W-1:0] idx,
                                           input bte_pkg::bte_state_type s);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (idx)
      `BTE_REG_GAIN: begin
        v[`BTE_IN_GAIN_W-1:0]  = s.in_gain;
        v[`BTE_GAIN_OUT_BIT]   = s.out_gain_hi;
      end
      `BTE_REG_GUARD_DUR: begin
        v[`BTE_CNT_W-1:0] = s.guard_dur;
      end
      `BTE_REG_ERR_STAT: begin
        v[`BTE_NUM_ERR-1:0] = s.err_st;
      end
      `BTE_REG_STATUS: begin
        v[`BTE_STAT_GUARD] = s.guard_act;
      end
      `BTE_REG_CONFIG: begin
        v[`BTE_CFG_LATCH_OFF] = s.latch_off;
        v[`BTE_CFG_SUPP_EN]   = s.supp_en;
      end
      `BTE_REG_ERR_MASK: begin
        v[`BTE_NUM_ERR-1:0] = s.err_mask;
      end
      `BTE_REG_SUPP_DLY: begin
        v[`BTE_CNT_W-1:0] = s.supp_dly;
      end
      default: begin
        v = 32'h00000000;
      end
    endcase
    return v;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    q_nxt      = q_r;
    cmd_trig   = 1'b0;
    w1c        = '0;
    guard_trig = 1'b0;
    guard_last = 16'h0000;

    // two-stage synchronisers for pin and sensors
    q_nxt.sync1 = {guard_trigger_pin, raw_sense};
    q_nxt.sync2 = q_r.sync1;
    q_nxt.pin_q = q_r.sync2[`BTE_NUM_ERR];
    pin_rise    = q_r.sync2[`BTE_NUM_ERR] & ~q_r.pin_q;

    // zero wait states, always okay
    q_nxt.hreadyout = 1'b1;
    q_nxt.hresp     = 1'b0;

    // address phase: capture writes, fetch read data
    q_nxt.wr_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        q_nxt.wr_pend = addr_ok;
        q_nxt.wr_idx  = addr_idx;
      end else begin
        q_nxt.rdata = addr_ok ? rd_value(addr_idx, q_r) : 32'h00000000;
      end
    end

    // data phase of a write
    if (q_r.wr_pend) begin
      unique case (q_r.wr_idx)
        `BTE_REG_GAIN: begin
          q_nxt.in_gain     = hwdata[`BTE_IN_GAIN_W-1:0];
          q_nxt.out_gain_hi = hwdata[`BTE_GAIN_OUT_BIT];
        end
        `BTE_REG_GUARD_DUR: begin
          q_nxt.guard_dur = hwdata[`BTE_CNT_W-1:0];
        end
        `BTE_REG_ERR_STAT: begin
          w1c = hwdata[`BTE_NUM_ERR-1:0];
        end
        `BTE_REG_CONFIG: begin
          q_nxt.latch_off = hwdata[`BTE_CFG_LATCH_OFF];
          q_nxt.supp_en   = hwdata[`BTE_CFG_SUPP_EN];
        end
        `BTE_REG_ERR_MASK: begin
          q_nxt.err_mask = hwdata[`BTE_NUM_ERR-1:0];
        end
        `BTE_REG_SUPP_DLY: begin
          q_nxt.supp_dly = hwdata[`BTE_CNT_W-1:0];
        end
        `BTE_REG_CMD: begin
          cmd_trig = hwdata[`BTE_CMD_TRIG_BIT];
        end
        default: begin
          cmd_trig = 1'b0;
        end
      endcase
    end

    // guard timer
    // a zero duration still gives one active cycle, never a stuck guard
    guard_trig = cmd_trig | pin_rise;
    guard_last = (q_r.guard_dur == 16'h0000) ? 16'h0000 : q_r.guard_dur - 16'h0001;
    if (guard_trig) begin
      q_nxt.guard_act = 1'b1;
      q_nxt.guard_cnt = 16'h0000;
    end else if (q_r.guard_act) begin
      if (q_r.guard_cnt >= guard_last) begin
        q_nxt.guard_act = 1'b0;
        q_nxt.guard_cnt = 16'h0000;
      end else begin
        q_nxt.guard_cnt = q_r.guard_cnt + 16'h0001;
      end
    end

    // error status: live or latched; a new set beats a same-cycle clear
    if (q_r.latch_off) begin
      q_nxt.err_st = err_set;
    end else begin
      q_nxt.err_st = (q_r.err_st & ~w1c) | err_set;
    end

    // ored error pin, doubles as interrupt
    q_nxt.irq = |(q_nxt.err_st & q_nxt.err_mask);
  end

  // ==========================================================
  // state register with documented reset values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r             <= '0;
      q_r.hreadyout   <= 1'b1;
      q_r.in_gain     <= `BTE_IN_GAIN_RST;
      q_r.out_gain_hi <= `BTE_OUT_GAIN_RST;
      q_r.guard_dur   <= `BTE_GUARD_DUR_RST;
      q_r.supp_dly    <= `BTE_SUPP_DLY_RST;
      q_r.err_mask    <= `BTE_ERR_MASK_RST;
      q_r.latch_off   <= `BTE_LATCH_OFF_RST;
      q_r.supp_en     <= `BTE_SUPP_EN_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // outputs straight from state
  assign hreadyout         = q_r.hreadyout;
  assign hresp             = q_r.hresp;
  assign hrdata            = q_r.rdata;
  assign guard_active_flag = q_r.guard_act;
  assign in_gain_sel       = q_r.in_gain;
  assign out_gain_high     = q_r.out_gain_hi;
  assign err_irq           = q_r.irq;

endmodule

// ### test/bte_host_model.sv
module bte_host_model (
  // clock and slave answer
  input wire logic  hclk,
  input wire logic  hready,
  input wire logic [31:0] hrdata,
  // master request
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end
  // bounded wait, a stuck slave ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      testbench.errors++;
      testbench.results();
    end
  endtask
  // one word, request held until hready high
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'h0};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
endmodule

// ### test/bte_top_props.sv
`include "bte_defines.svh"
module bte_top_props (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // pins
  input wire logic        guard_trigger_pin,
  input wire logic        guard_active_flag,
  input wire logic [`BTE_IN_GAIN_W-1:0] in_gain_sel,
  input wire logic        out_gain_high,
  input wire logic        err_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ========
  // bus answer, zero wait and always okay
  bus_ready_a: assert property (hreadyout) else $error("wait state seen");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  rdata_hold_a: assert property ($changed(hrdata) |->
    $past(hsel && hready && htrans[1] && !hwrite)) else $error("read data moved");
  // ========
  // gain selection
  gain_rst_a: assert property ($rose(hresetn) |-> in_gain_sel == 4'h0 &&
    !out_gain_high && !guard_active_flag && !err_irq) else $error("bad reset state");
  gain_wr_a: assert property ($changed({in_gain_sel, out_gain_high}) |->
    $past(hwrite, 2)) else $error("gain moved without write");
  // ========
  // guard timing
  guard_cause_a: assert property ($rose(guard_active_flag) |-> $past(hwrite, 2) ||
    $past(guard_trigger_pin, 2) || $past(guard_trigger_pin, 3)) else $error("guard no cause");
  guard_pin_a: assert property ($rose(guard_trigger_pin) |->
    ##[2:4] guard_active_flag) else $error("pin did not start guard");
  guard_end_a: assert property ($rose(guard_active_flag) |->
    ##[1:1000] !guard_active_flag) else $error("guard never ended");
endmodule

bind bte_top bte_top_props i_bte_top_props (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .guard_trigger_pin, .guard_active_flag,
  .in_gain_sel, .out_gain_high, .err_irq);

// ### test/testbench.sv
`include "bte_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // signals
  typedef struct packed {logic w; logic [5:0] idx; logic [31:0] v;} bte_row_type;
  logic hclk, hresetn, pin, hsel, hwrite, hrdy, hresp, gact, ohi, irq;
  logic [4:0]  sense;
  logic [3:0]  igs;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, d;
  int errors, total_checks, n;
  bte_row_type rows[17] = '{'{0, `BTE_REG_GUARD_DUR, 32'h64}, '{0, `BTE_REG_SUPP_DLY, 32'ha},
    '{0, `BTE_REG_CONFIG, 32'h2}, '{0, `BTE_REG_ERR_MASK, 32'h0}, '{0, `BTE_REG_GAIN, 32'h0},
    '{0, `BTE_REG_STATUS, 32'h0}, '{0, `BTE_REG_CMD, 32'h0}, '{1, 6'h3f, 32'hffffffff},
    '{0, 6'h3f, 32'h0}, '{1, `BTE_REG_GAIN, 32'h1f}, '{0, `BTE_REG_GAIN, 32'h1f},
    '{1, `BTE_REG_GUARD_DUR, 32'h8}, '{0, `BTE_REG_GUARD_DUR, 32'h8},
    '{1, `BTE_REG_SUPP_DLY, 32'h3}, '{0, `BTE_REG_SUPP_DLY, 32'h3},
    '{1, `BTE_REG_STATUS, 32'hffff}, '{0, `BTE_REG_STATUS, 32'h0}};
  // ========
  // parts
  bte_host_model i_host (.hclk(hclk), .hready(hrdy), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
  bte_top i_bte_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .guard_trigger_pin(pin),
    .iov_sense(sense[0]), .clip_sense(sense[1]), .gain_sense(sense[2]),
    .clamp_sense(sense[3]), .outfault_sense(sense[4]), .guard_active_flag(gact),
    .in_gain_sel(igs), .out_gain_high(ohi), .err_irq(irq));
  // ========
  // helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  // cycles the guard flag stays high, capped so a stuck flag ends
  task automatic glen(output int k);
    k = 0;
    #1;
    while (gact === 1'b1 && k < 200) begin
      @(posedge hclk);
      #1;
      k++;
    end
    // a guard that never drops is a failure, not a silent pass
    if (k >= 200) begin
      errors++;
      results();
    end
  endtask
  task automatic results;
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ========
  // main sequence
  initial begin
    hresetn = 1'b0;
    pin = 1'b0;
    sense = 5'h0;
    cyc(4);
    hresetn <= 1'b1;
    #1;
    chk("reset pins", 32'h0, 32'({gact, ohi, igs, irq}));
    foreach (rows[k]) begin
      i_host.xfer(rows[k].w, rows[k].idx, rows[k].v, d);
      if (!rows[k].w) chk($sformatf("reg %h", rows[k].idx), rows[k].v, d);
    end
    #1;
    chk("gain pins", 32'h1f, 32'({ohi, igs}));
    i_host.xfer(1, `BTE_REG_CMD, 32'h20, d);
    glen(n);
    chk("guard length", 32'h8, n);
    i_host.xfer(1, `BTE_REG_CMD, 32'h20, d);
    i_host.xfer(0, `BTE_REG_STATUS, 32'h0, d);
    chk("guard busy", 32'h1, d);
    i_host.xfer(1, `BTE_REG_CMD, 32'h20, d);
    glen(n);
    chk("retrigger length", 32'h8, n);
    @(posedge hclk);
    pin <= 1'b1;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (gact !== 1'b1 && n < 6);
    chk("pin start", 32'h1, gact);
    glen(n);
    @(posedge hclk);
    pin <= 1'b0;
    // each sensor in turn, latched, raises the interrupt, cleared by w1c
    i_host.xfer(1, `BTE_REG_ERR_MASK, 32'h1f, d);
    for (int i = 0; i < 5; i++) begin
      @(posedge hclk);
      sense <= 5'(1 << i);
      cyc(12);
      sense <= 5'h0;
      #1;
      chk("irq", 32'h1, irq);
      cyc(12);
      i_host.xfer(0, `BTE_REG_ERR_STAT, 32'h0, d);
      chk("latched", 32'(1 << i), d);
      i_host.xfer(1, `BTE_REG_ERR_STAT, 32'(1 << i), d);
      i_host.xfer(0, `BTE_REG_ERR_STAT, 32'h0, d);
      chk("cleared", 32'h0, d);
    end
    // pulse shorter than the delay must not pass the filter
    sense <= 5'h1;
    cyc(2);
    sense <= 5'h0;
    cyc(12);
    i_host.xfer(0, `BTE_REG_ERR_STAT, 32'h0, d);
    chk("short pulse", 32'h0, d);
    // masked and unlatched: status follows the sensor, no interrupt
    i_host.xfer(1, `BTE_REG_ERR_MASK, 32'h0, d);
    i_host.xfer(1, `BTE_REG_CONFIG, 32'h3, d);
    sense <= 5'h2;
    cyc(12);
    #1;
    chk("masked irq", 32'h0, irq);
    i_host.xfer(0, `BTE_REG_ERR_STAT, 32'h0, d);
    chk("live set", 32'h2, d);
    sense <= 5'h0;
    cyc(12);
    i_host.xfer(0, `BTE_REG_ERR_STAT, 32'h0, d);
    chk("live clear", 32'h0, d);
    // sensor held off while the guard runs
    i_host.xfer(1, `BTE_REG_CONFIG, 32'h2, d);
    i_host.xfer(1, `BTE_REG_GUARD_DUR, 32'h40, d);
    i_host.xfer(1, `BTE_REG_CMD, 32'h20, d);
    sense <= 5'h4;
    cyc(12);
    i_host.xfer(0, `BTE_REG_ERR_STAT, 32'h0, d);
    chk("suppressed", 32'h0, d);
    sense <= 5'h0;
    glen(n);
    // reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    cyc(2);
    hresetn <= 1'b1;
    #1;
    chk("reset again", 32'h0, 32'({gact, ohi, igs, irq}));
    // first access after a mid-run reset, duration back to its reset value
    i_host.xfer(1'b0, `BTE_REG_GUARD_DUR, 32'h0, d);
    chk("duration after reset", 32'(`BTE_GUARD_DUR_RST), d);
    results();
  end
endmodule
